// >>> rtl/pra_arbiter.sv
`include "pra_params.svh"

module pra_arbiter (
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`PRA_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// pci pins, asynchronous
	input  wire logic [2:0]             req_n,
	input  wire logic                   frame_n,
	input  wire logic                   irdy_n,
	output logic [2:0]                  gnt_n,
	// processor side, same clock
	input  wire logic                   cpu_req,
	output logic                        cpu_gnt,
	input  wire logic                   pci_retry,
	input  wire logic                   buffers_empty,
	output logic                        xbus_hold
);
	import pra_pkg::*;

	// synchronisers: req_n[2:0], frame_n, irdy_n
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;

	// reset to the idle high level so no false request follows reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 5'h1F;
			sync2_ff <= 5'h1F;
		end else begin
			sync1_ff <= {irdy_n, frame_n, req_n};
			sync2_ff <= sync1_ff;
		end
	end

	logic [2:0] req_s;
	logic       frame_s;
	logic       irdy_s;
	assign req_s   = ~sync2_ff[2:0];
	assign frame_s = ~sync2_ff[3];
	assign irdy_s  = ~sync2_ff[4];

	// registers
	logic [7:0] retry_ctrl_ff;
	logic [7:0] policy_ctrl_ff;
	logic [7:0] status;
	logic [7:0] idx;
	logic       addr_ok;
	logic       wr_en;
	logic       wr_retry;
	logic       wr_policy;

	assign idx     = paddr[9:2];
	assign addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
		(idx == `PRA_IDX_RETRY_CTRL || idx == `PRA_IDX_POLICY_CTRL ||
		 idx == `PRA_IDX_STATUS);
	assign wr_en     = psel && penable && pwrite;
	assign wr_retry  = wr_en && addr_ok && idx == `PRA_IDX_RETRY_CTRL;
	assign wr_policy = wr_en && addr_ok && idx == `PRA_IDX_POLICY_CTRL;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_ctrl_ff <= `PRA_RST_RETRY_CTRL;
		end else if (wr_retry) begin
			retry_ctrl_ff <= pwdata[7:0] | (8'h01 << `PRA_RM_RSVD_ONE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			policy_ctrl_ff <= `PRA_RST_POLICY_CTRL;
		end else if (wr_policy) begin
			policy_ctrl_ff <= pwdata[7:0] & `PRA_PC_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite && !addr_ok) begin
			// refused reads return zero, never a neighbour's value
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (idx)
				`PRA_IDX_RETRY_CTRL:  prdata <= {24'h000000, retry_ctrl_ff};
				`PRA_IDX_POLICY_CTRL: prdata <= {24'h000000, policy_ctrl_ff};
				`PRA_IDX_STATUS:      prdata <= {24'h000000, status};
				default:              prdata <= 32'h0000_0000;
			endcase
		end
	end

	logic       alt_en;
	logic [2:0] fix_code;
	logic [2:0] rot_bits;
	logic [1:0] mask_len;
	logic [2:0] mask_en;
	logic       hold_en;
	assign alt_en   = policy_ctrl_ff[`PRA_PC_ALT];
	assign fix_code = policy_ctrl_ff[`PRA_PC_FIX_HI:`PRA_PC_FIX_LO];
	assign rot_bits = policy_ctrl_ff[`PRA_PC_ROT_HI:`PRA_PC_ROT_LO];
	assign mask_len = retry_ctrl_ff[`PRA_RM_LEN_HI:`PRA_RM_LEN_LO];
	assign mask_en  = retry_ctrl_ff[`PRA_RM_EN_HI:`PRA_RM_EN_LO];
	assign hold_en  = retry_ctrl_ff[`PRA_RM_HOLD];

	// fixed order table, packed highest first
	function automatic logic [5:0] fixed_order(input logic [2:0] code);
		case (code)
			3'b000:  fixed_order = {2'd0, 2'd1, 2'd2};
			3'b001:  fixed_order = {2'd1, 2'd0, 2'd2};
			3'b010:  fixed_order = {2'd0, 2'd2, 2'd1};
			3'b100:  fixed_order = {2'd1, 2'd2, 2'd0};
			3'b110:  fixed_order = {2'd2, 2'd1, 2'd0};
			3'b111:  fixed_order = {2'd2, 2'd0, 2'd1};
			// reserved codes fall back to the reset order
			default: fixed_order = {2'd0, 2'd1, 2'd2};
		endcase
	endfunction

	// state
	pra_state_t state_ff;
	pra_state_t nxt_state;
	pra_line_t  owner_ff;
	pra_line_t  nxt_owner;
	logic [5:0] ord_ff;
	logic [4:0] wait_ff;
	logic [1:0] ext_ff;
	logic       cpu_turn_ff;
	logic [2:0] masked;
	logic [2:0] eligible;
	logic       pick_ok;
	pra_line_t  pick;
	logic       retry_hit;

	assign eligible  = req_s & ~(masked & mask_en);
	assign retry_hit = pci_retry &&
		(state_ff == PRA_BUSY || state_ff == PRA_GRANT);

	// a new owner only once the write buffers have drained
	logic grant_ok;
	assign grant_ok = pick_ok && buffers_empty;

	// first eligible line in the live order
	always_comb begin
		pick_ok = 1'b0;
		pick    = 2'd0;
		for (int i = 0; i < 3; i++) begin
			if (!pick_ok && eligible[ord_ff[5-2*i -: 2]]) begin
				pick_ok = 1'b1;
				pick    = ord_ff[5-2*i -: 2];
			end
		end
	end

	// live priority order, rotated after grants
	logic [5:0] nxt_ord;
	always_comb begin
		nxt_ord = ord_ff;
		if (wr_policy) begin
			nxt_ord = fixed_order(
				pwdata[`PRA_PC_FIX_HI:`PRA_PC_FIX_LO]);
		end else if (state_ff == PRA_IDLE && nxt_state == PRA_GRANT &&
				rot_bits[pick]) begin
			// winner moves to the tail, others keep relative rank
			if (ord_ff[5:4] == pick) begin
				nxt_ord = {ord_ff[3:0], pick};
			end else if (ord_ff[3:2] == pick) begin
				nxt_ord = {ord_ff[5:4], ord_ff[1:0], pick};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ord_ff <= {2'd0, 2'd1, 2'd2};
		end else begin
			ord_ff <= nxt_ord;
		end
	end

	// arbitration sequence
	always_comb begin
		nxt_state = state_ff;
		nxt_owner = owner_ff;
		case (state_ff)
			PRA_IDLE: begin
				if (alt_en) begin
					if (cpu_req && (cpu_turn_ff || !pick_ok)) begin
						nxt_state = PRA_CPU;
					end else if (grant_ok) begin
						nxt_state = PRA_GRANT;
						nxt_owner = pick;
					end
				end else if (cpu_req) begin
					nxt_state = PRA_CPU;
				end else if (grant_ok) begin
					nxt_state = PRA_GRANT;
					nxt_owner = pick;
				end
			end
			PRA_GRANT: begin
				if (frame_s) begin
					nxt_state = PRA_BUSY;
				end else if (wait_ff == `PRA_FRAME_WAIT - 5'd1 ||
						!req_s[owner_ff] || retry_hit) begin
					nxt_state = PRA_FLUSH;
				end
			end
			PRA_BUSY: begin
				// other requests ignored until the bus goes idle
				// a retry here masks and extends the hold; the master ends its frame
				if (!frame_s && !irdy_s) begin
					nxt_state = PRA_FLUSH;
				end
			end
			PRA_FLUSH: begin
				if (buffers_empty && ext_ff == 2'd0) begin
					nxt_state = PRA_IDLE;
				end
			end
			PRA_CPU: begin
				if (!cpu_req) begin
					nxt_state = PRA_IDLE;
				end
			end
			default: nxt_state = PRA_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= PRA_IDLE;
			owner_ff <= 2'd0;
		end else begin
			state_ff <= nxt_state;
			owner_ff <= nxt_owner;
		end
	end

	// frame wait counter for the grant window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= 5'd0;
		end else if (state_ff == PRA_GRANT) begin
			wait_ff <= wait_ff + 5'd1;
		end else begin
			wait_ff <= 5'd0;
		end
	end

	// cpu turn flag for alternation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_turn_ff <= 1'b0;
		end else if (!alt_en) begin
			// a stale turn would let the cpu jump the queue later
			cpu_turn_ff <= 1'b0;
		end else if (state_ff == PRA_BUSY && nxt_state == PRA_FLUSH) begin
			cpu_turn_ff <= 1'b1;
		end else if (state_ff == PRA_CPU) begin
			cpu_turn_ff <= 1'b0;
		end
	end

	// hold extension after a retry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_ff <= 2'd0;
		end else if (retry_hit && hold_en) begin
			ext_ff <= `PRA_HOLD_EXTRA;
		end else if (ext_ff != 2'd0) begin
			ext_ff <= ext_ff - 2'd1;
		end
	end

	// one mask timer per request line
	logic [2:0] mask_start;
	assign mask_start = {3{retry_hit}} & mask_en &
		(3'h1 << owner_ff);
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_mask
			pra_retry_mask u_mask (
				.pclk    (pclk),
				.presetn (presetn),
				.start   (mask_start[g]),
				.len     (mask_len),
				.masked  (masked[g])
			);
		end
	endgenerate

	// grant outputs from flops so pins never glitch
	logic [2:0] gnt_n_ff;
	logic       cpu_gnt_ff;
	logic       hold_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gnt_n_ff   <= 3'h7;
			cpu_gnt_ff <= 1'b0;
			hold_ff    <= 1'b0;
		end else begin
			gnt_n_ff   <= (nxt_state == PRA_GRANT || nxt_state == PRA_BUSY) ?
				~(3'h1 << nxt_owner) : 3'h7;
			cpu_gnt_ff <= (nxt_state == PRA_CPU);
			hold_ff    <= (nxt_state == PRA_GRANT) || (nxt_state == PRA_BUSY)
				|| (retry_hit && hold_en) || (ext_ff > 2'd1);
		end
	end

	assign gnt_n     = gnt_n_ff;
	assign cpu_gnt   = cpu_gnt_ff;
	assign xbus_hold = hold_ff;
	// bit 2 is shared: owner bit 0 or the cpu state
	assign status    = {cpu_turn_ff, masked, owner_ff, state_ff[1:0]}
		| {5'h00, state_ff[2], 2'b00};
endmodule

// >>> rtl/pra_params.svh
`ifndef PRA_PARAMS_SVH
`define PRA_PARAMS_SVH

// register indices; byte address is four times the index
`define PRA_IDX_RETRY_CTRL   8'h43
`define PRA_IDX_POLICY_CTRL  8'h44
`define PRA_IDX_STATUS       8'h45
`define PRA_ADDR_W           12

// retry_mask_control fields
`define PRA_RST_RETRY_CTRL   8'h80
`define PRA_RM_GRANT_EMPTY   7
`define PRA_RM_RSVD_ONE      6
`define PRA_RM_EN_HI         5
`define PRA_RM_EN_LO         3
`define PRA_RM_LEN_HI        2
`define PRA_RM_LEN_LO        1
`define PRA_RM_HOLD          0

// arbitration_policy_control fields
`define PRA_RST_POLICY_CTRL  8'h00
`define PRA_PC_ALT           7
`define PRA_PC_FIX_HI        6
`define PRA_PC_FIX_LO        4
`define PRA_PC_ROT_HI        2
`define PRA_PC_ROT_LO        0
`define PRA_PC_WMASK         8'hF7

// timing in pci clocks
`define PRA_MASK_16          7'd16
`define PRA_MASK_32          7'd32
`define PRA_MASK_64          7'd64
`define PRA_FRAME_WAIT       5'd16
`define PRA_HOLD_EXTRA       2'd2

`endif

// >>> rtl/pra_pkg.sv
package pra_pkg;
	typedef enum logic [2:0] {
		PRA_IDLE  = 3'b000,
		PRA_GRANT = 3'b001,
		PRA_BUSY  = 3'b010,
		PRA_FLUSH = 3'b011,
		PRA_CPU   = 3'b100
	} pra_state_t;

	typedef logic [1:0] pra_line_t;
endpackage

// >>> rtl/pra_retry_mask.sv
`include "pra_params.svh"

module pra_retry_mask (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       start,
	input  wire logic [1:0] len,
	// state
	output logic            masked
);
	logic [6:0] cnt_ff;
	logic [6:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (start) begin
			case (len)
				2'b01:   nxt_cnt = `PRA_MASK_16;
				2'b10:   nxt_cnt = `PRA_MASK_32;
				2'b11:   nxt_cnt = `PRA_MASK_64;
				default: nxt_cnt = 7'h00;
			endcase
		end else if (cnt_ff != 7'h00) begin
			nxt_cnt = cnt_ff - 7'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 7'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign masked = (cnt_ff != 7'h00);
endmodule

// >>> tb/pra_arbiter_chk.sv
`include "pra_params.svh"

module pra_arbiter_chk (
	// clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// apb
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic [`PRA_ADDR_W-1:0] paddr,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// arbitration
	input wire logic                   frame_n,
	input wire logic [2:0]             gnt_n,
	input wire logic                   cpu_gnt,
	input wire logic                   pci_retry,
	input wire logic                   buffers_empty
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// grant standing with no frame; sync delay adds a little slack
	logic [5:0] idle_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_ff <= 6'h00;
		else if (gnt_n == 3'b111 || !frame_n)
			idle_ff <= 6'h00;
		else if (idle_ff != 6'h3F)
			idle_ff <= idle_ff + 6'h01;
	end

	sequence s_retried;
		pci_retry && gnt_n != 3'b111;
	endsequence

	sequence s_released;
		##[1:3] gnt_n == 3'b111;
	endsequence

	a_grant_single: assert property ($onehot0(~gnt_n))
		else $error("two pci grants at once");
	a_cpu_alone: assert property (cpu_gnt |-> gnt_n == 3'b111)
		else $error("cpu and pci granted together");
	a_switch_idle: assert property (gnt_n != 3'b111 |=>
		gnt_n == $past(gnt_n) || gnt_n == 3'b111)
		else $error("grant moved without idle gap");
	a_frame_limit: assert property (idle_ff <= 6'h12)
		else $error("grant kept without frame");
	a_retry_drop: assert property (s_retried |-> s_released)
		else $error("retried grant not withdrawn");
	a_err_align: assert property (
		psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_ready_now: assert property (psel && penable |-> pready)
		else $error("access not answered");
	a_read_narrow: assert property (
		$rose(penable) |-> prdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_flush_first: assert property (
		$fell(&gnt_n) |-> $past(buffers_empty))
		else $error("grant given before buffers flushed");
endmodule

bind pra_arbiter pra_arbiter_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.frame_n(frame_n), .gnt_n(gnt_n), .cpu_gnt(cpu_gnt),
	.pci_retry(pci_retry), .buffers_empty(buffers_empty)
);

// >>> tb/pra_arbiter_test.sv
`include "pra_params.svh"

module pra_arbiter_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pra_pkg::*;

	logic                   pclk = 1'b0, presetn = 1'b0;
	logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [`PRA_ADDR_W-1:0] paddr = '0;
	logic [31:0]            pwdata = 32'h0, prdata, rd;
	logic                   pready, pslverr, err, frame_n, irdy_n;
	logic                   cpu_gnt, xbus_hold, lazy = 1'b0;
	logic                   cpu_req = 1'b0, pci_retry = 1'b0;
	logic                   buffers_empty = 1'b1;
	logic [2:0]             req_n, gnt_n, ln, want = 3'b000;
	int                     errors = 0, n_compared = 0, cycles = 0;
	int                     i, j, c;
	// expected lines, first at the top two bits
	logic [5:0] ord [6] = '{6'h06, 6'h12, 6'h09, 6'h18, 6'h24, 6'h21};
	logic [7:0] fix [6] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h60, 8'h70};
	logic [7:0] rot [2] = '{8'h18, 8'h15};
	logic [7:0] rpol [2] = '{8'h07, 8'h01};
	logic [7:0] rctl [3] = '{8'hCB, 8'hC9, 8'hC4};

	pra_arbiter DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .req_n(req_n),
		.frame_n(frame_n), .irdy_n(irdy_n), .gnt_n(gnt_n),
		.cpu_req(cpu_req), .cpu_gnt(cpu_gnt), .pci_retry(pci_retry),
		.buffers_empty(buffers_empty), .xbus_hold(xbus_hold));

	pra_pci_agent u_agents (.pclk(pclk), .presetn(presetn), .want(want),
		.lazy(lazy), .gnt_n(gnt_n), .req_n(req_n), .frame_n(frame_n),
		.irdy_n(irdy_n));

	always #12.5 pclk = ~pclk;

	task test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done;
		end
	end

	task chk(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_gnt;
		for (j = 0; j < 100 && gnt_n === 3'b111; j++)
			@(posedge pclk);
	endtask

	// waits for an owner, then until the bus is free again
	task grant(input logic keep);
		int k;
		ln = 3'h7;
		for (k = 0; k < 100 && ln == 3'h7; k++) begin
			@(posedge pclk);
			if (cpu_gnt === 1'b1)
				ln = 3'h3;
			for (i = 0; i < 3; i++)
				if (gnt_n[i] === 1'b0)
					ln = i[2:0];
		end
		// request held until frame starts, else the grant is lost
		while (ln < 3'h3 && frame_n !== 1'b0 && k < 200) begin
			@(posedge pclk);
			k++;
		end
		if (ln < 3'h3 && !keep)
			want[ln] <= 1'b0;
		if (ln == 3'h3)
			cpu_req <= 1'b0;
		while ((gnt_n !== 3'b111 || cpu_gnt !== 1'b0) && k < 300) begin
			@(posedge pclk);
			k++;
		end
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h110, 8'h00);
		chk("policy reset", 32'h0, rd);
		apb(1'b1, 12'h110, 8'hFF);
		apb(1'b0, 12'h110, 8'h00);
		chk("policy rw", 32'hF7, rd);
		apb(1'b0, 12'h111, 8'h00);
		chk("misaligned", 32'h1, err);
		chk("misaligned data", 32'h0, rd);
		apb(1'b0, 12'h3FC, 8'h00);
		chk("unmapped", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		for (c = 0; c < 6; c++) begin
			apb(1'b1, 12'h110, fix[c]);
			want <= 3'b111;
			buffers_empty <= 1'b0;
			repeat (6) @(posedge pclk);
			buffers_empty <= 1'b1;
			for (j = 0; j < 3; j++) begin
				grant(1'b0);
				chk("order", ord[c][5-2*j -: 2], ln);
			end
		end
		for (c = 0; c < 2; c++) begin
			apb(1'b1, 12'h110, rpol[c]);
			want <= 3'b111;
			for (j = 0; j < 4; j++) begin
				grant(1'b1);
				chk("rotation", rot[c][7-2*j -: 2], ln);
			end
			want <= 3'b000;
			repeat (40) @(posedge pclk);
		end
		apb(1'b1, 12'h110, 8'h00);
		for (c = 0; c < 3; c++) begin
			apb(1'b1, 12'h10C, rctl[c]);
			apb(1'b0, 12'h10C, 8'h00);
			chk("retry rw", rctl[c], rd);
			lazy <= 1'b1;
			want <= 3'b011;
			wait_gnt;
			pci_retry <= 1'b1;
			@(posedge pclk);
			pci_retry <= 1'b0;
			@(posedge pclk);
			chk("hold", c != 2, xbus_hold);
			@(posedge pclk);
			chk("hold", c != 2, xbus_hold);
			lazy <= 1'b0;
			grant(1'b0);
			chk("after retry", (c == 0) ? 3'h1 : 3'h0, ln);
			grant(1'b0);
		end
		lazy <= 1'b1;
		want <= 3'b100;
		wait_gnt;
		for (j = 0; j < 40 && gnt_n !== 3'b111; j++)
			@(posedge pclk);
		chk("frame wait", 32'h1, j >= 14 && j <= 18);
		want <= 3'b000;
		repeat (30) @(posedge pclk);
		lazy <= 1'b0;
		cpu_req <= 1'b1;
		want <= 3'b001;
		grant(1'b0);
		chk("cpu first", 32'h3, ln);
		grant(1'b0);
		chk("pci next", 32'h0, ln);
		apb(1'b1, 12'h110, 8'h80);
		want <= 3'b011;
		wait_gnt;
		cpu_req <= 1'b1;
		for (j = 0; j < 3; j++) begin
			grant(1'b0);
			chk("alternation", 6'h0D >> (4 - 2 * j) & 6'h03, ln);
		end
		test_done;
	end
endmodule

// >>> tb/pra_pci_agent.sv
module pra_pci_agent (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// lines asking, and refusal to start a frame
	input  wire logic [2:0] want,
	input  wire logic       lazy,
	// pci pins
	input  wire logic [2:0] gnt_n,
	output logic      [2:0] req_n,
	output logic            frame_n,
	output logic            irdy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// phase 1-3 frame low, 2-4 irdy low; both driven high at every other phase
	logic [2:0] phase_ff;
	logic       done_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			req_n <= 3'b111;
		else
			req_n <= ~want;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff <= 3'h0;
			done_ff  <= 1'b0;
		end else begin
			if (gnt_n == 3'b111)
				done_ff <= 1'b0;
			if (phase_ff != 3'h0)
				phase_ff <= phase_ff + 3'h1;
			else if (gnt_n != 3'b111 && !done_ff && !lazy) begin
				phase_ff <= 3'h1;
				done_ff  <= 1'b1;
			end
		end
	end

	assign frame_n = !(phase_ff >= 3'h1 && phase_ff <= 3'h3);
	assign irdy_n  = !(phase_ff >= 3'h2 && phase_ff <= 3'h4);
endmodule
